// ===== logic/board_ctl_pkg.sv
// Constants for the board control register bank
package board_ctl_pkg;
  localparam int          NREG      = 51;
  localparam logic [15:0] WIN_BASE  = 16'h0C80;
  localparam int          WIN_BITS  = 6;
  localparam logic [6:0]  PROD_CODE = 7'h2A;  // Arbitrary value
  localparam logic [7:0]  RST_VAL   = 8'h00;
  localparam int          NSYNC     = 34;
  localparam int          OFF_PROD  = 'h00;
  localparam int          OFF_PSTAT = 'h01;
  localparam int          OFF_JMP   = 'h02;
  localparam int          OFF_TCTL  = 'h03;
  localparam int          OFF_TSTA  = 'h04;
  localparam int          OFF_SPIB  = 'h09;
  localparam int          OFF_AUXP  = 'h10;
  localparam int          OFF_GDIR  = 'h21;
  localparam int          OFF_GOUT  = 'h23;
  localparam int          OFF_GIN   = 'h24;
  localparam int          OFF_GMSK  = 'h25;
  localparam int          OFF_GSTA  = 'h26;
  localparam int          OFF_WDOG  = 'h28;
  localparam int          OFF_AUXI  = 'h2B;
  localparam int          OFF_SECT  = 'h30;
  localparam int          OFF_SEST  = 'h31;
  localparam logic [3:0]  LAD_START = 4'h0;
  localparam logic [3:0]  LAD_SYNC  = 4'h0;
  localparam logic [3:0]  LAD_IDLE  = 4'hF;

  typedef enum logic [1:0] {
    CL_NONE = 2'b00,
    CL_POR  = 2'b01,
    CL_PLAT = 2'b10,
    CL_SEL  = 2'b11
  } rst_class_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CYC  = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDAT = 3'b011,
    ST_HTAR = 3'b100,
    ST_SYNC = 3'b101,
    ST_RDAT = 3'b110,
    ST_PTAR = 3'b111
  } lpc_state_e;

  function automatic rst_class_e reg_class(input int i);
    case (i)
      'h10, 'h11:             reg_class = CL_POR;
      'h21, 'h22, 'h23, 'h27: reg_class = CL_SEL;
      'h06, 'h07, 'h0F, 'h24, 'h2D: reg_class = CL_NONE;
      default:                reg_class = (i > 'h12 && i < 'h21) ? CL_NONE : CL_PLAT;
    endcase
  endfunction : reg_class

  function automatic logic [7:0] wr_mask(input int i);
    case (i)
      'h00: wr_mask = 8'h80;
      'h02: wr_mask = 8'h70;
      'h03: wr_mask = 8'hF7;
      'h04: wr_mask = 8'hC0;
      'h09: wr_mask = 8'hFC;
      'h0E: wr_mask = 8'h76;
      'h10: wr_mask = 8'h03;
      'h11: wr_mask = 8'h70;
      'h12: wr_mask = 8'h04;
      'h28: wr_mask = 8'hF6;
      'h2A: wr_mask = 8'h03;
      'h2B: wr_mask = 8'hF0;
      'h2C: wr_mask = 8'h01;
      'h05, 'h08, 'h0A, 'h0B, 'h0C, 'h0D, 'h21, 'h22, 'h23, 'h25, 'h27,
      'h29, 'h2E, 'h2F, 'h30, 'h32: wr_mask = 8'hFF;
      default: wr_mask = 8'h00;
    endcase
  endfunction : wr_mask

  function automatic logic [7:0] w1c_mask(input int i);
    case (i)
      'h04:    w1c_mask = 8'h07;
      'h26:    w1c_mask = 8'hFF;
      'h28:    w1c_mask = 8'h01;
      'h31:    w1c_mask = 8'h0F;
      default: w1c_mask = 8'h00;
    endcase
  endfunction : w1c_mask

  function automatic logic [7:0] rdclr_mask(input int i);
    rdclr_mask = (i == 'h09) ? 8'h02 : 8'h00;
  endfunction : rdclr_mask
endpackage : board_ctl_pkg

// ===== logic/board_control_register_bank.sv
// Board control register bank behind an LPC I/O slave
// Contract
// - Power-on class registers reset only at power-up, never at platform reset.
// - Platform class registers clear at every platform reset.
// - Selectable class acts as platform class while power select is clear.
// - Selectable class resets only at power-up while power select is set.
// - Status and reserved locations ignore resets; read from inputs or zeros.
// - Read-to-clear bits clear after read; write-one-clear bits clear where one written.
// - Only single-byte LPC I/O cycles; wide values are two byte accesses.
// - Interrupt status bits stay set until host writes one to them or a platform reset clears them.
// - Enabled interrupt slot is low without and high with pending interrupt.
module board_control_register_bank (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    lframe_n,
  input  wire logic [3:0]              lad_i,
  output logic      [3:0]              lad_o,
  output logic                         lad_oe,
  input  wire logic                    plat_rst,
  input  wire logic                    power_select_control_bit,
  input  wire logic [7:0]              prod_status,
  input  wire logic [2:0]              jumper_in,
  input  wire logic [1:0]              tmr_in,
  input  wire logic                    spi_busy,
  input  wire logic                    battlow,
  input  wire logic [7:0]              gpio_in,
  input  wire logic [2:0]              timer_evt,
  input  wire logic                    spi_evt,
  input  wire logic                    wdt_evt,
  input  wire logic [3:0]              sys_evt,
  output logic [7:0]                   gpio_o,
  output logic [7:0]                   gpio_oe,
  output logic                         programmable_indicator,
  output logic [board_ctl_pkg::NREG-1:0][7:0] cfg_o,
  output logic [7:0]                   slot_en,
  output logic [7:0]                   slot_lvl
);
  localparam int N = board_ctl_pkg::NREG;
  localparam int S = board_ctl_pkg::NSYNC;

  logic [S-1:0] s1_reg;
  logic [S-1:0] s2_reg;
  logic [S-1:0] s3_reg;
  logic [S-1:0] pins;
  logic         plat_s;
  logic         psen_s;
  logic [7:0]   gpio_s;
  logic [7:0]   gpio_d;
  logic [8:0]   evt_rise;

  assign pins = {gpio_in, sys_evt, wdt_evt, spi_evt, timer_evt, battlow, spi_busy, tmr_in,
                 jumper_in, prod_status, power_select_control_bit, plat_rst};

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign plat_s   = s2_reg[0];
  assign psen_s   = s2_reg[1];
  assign gpio_s   = s2_reg[33:26];
  assign gpio_d   = s3_reg[33:26];
  assign evt_rise = s2_reg[25:17] & ~s3_reg[25:17];

  // LPC slave
  board_ctl_pkg::lpc_state_e st_reg, st_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic [15:0] addr_reg, addr_next;
  logic        dir_reg, dir_next;
  logic [7:0]  data_reg, data_next;
  logic        wr_stb;
  logic        rd_stb;
  logic [5:0]  off;
  logic [15:0] addr_sh;
  logic [7:0]  rd_val;

  assign off     = addr_reg[5:0];
  assign addr_sh = {addr_reg[11:0], lad_i};
  assign wr_stb  = (st_reg == board_ctl_pkg::ST_SYNC) && dir_reg;
  assign rd_stb  = (st_reg == board_ctl_pkg::ST_SYNC) && !dir_reg;

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    addr_next = addr_reg;
    dir_next  = dir_reg;
    data_next = data_reg;
    case (st_reg)
      board_ctl_pkg::ST_IDLE: begin
        if (!lframe_n && lad_i == board_ctl_pkg::LAD_START) st_next = board_ctl_pkg::ST_CYC;
      end
      board_ctl_pkg::ST_CYC: begin
        cnt_next = 2'h0;
        if (!lframe_n) st_next = board_ctl_pkg::ST_CYC;
        else if (lad_i[3:2] == 2'h0) begin
          dir_next = lad_i[1];
          st_next  = board_ctl_pkg::ST_ADDR;
        end else st_next = board_ctl_pkg::ST_IDLE;
      end
      board_ctl_pkg::ST_ADDR: begin
        addr_next = addr_sh;
        cnt_next  = cnt_reg + 2'h1;
        if (cnt_reg == 2'h3) begin
          if (addr_sh[15:board_ctl_pkg::WIN_BITS] !=
              board_ctl_pkg::WIN_BASE[15:board_ctl_pkg::WIN_BITS])
            st_next = board_ctl_pkg::ST_IDLE;
          else st_next = dir_reg ? board_ctl_pkg::ST_WDAT : board_ctl_pkg::ST_HTAR;
        end
      end
      board_ctl_pkg::ST_WDAT: begin
        data_next = {lad_i, data_reg[7:4]};
        cnt_next  = cnt_reg + 2'h1;
        if (cnt_reg[0]) begin
          cnt_next = 2'h0;
          st_next  = board_ctl_pkg::ST_HTAR;
        end
      end
      board_ctl_pkg::ST_HTAR: begin
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg[0]) st_next = board_ctl_pkg::ST_SYNC;
      end
      board_ctl_pkg::ST_SYNC: begin
        cnt_next = 2'h0;
        if (!dir_reg) data_next = rd_val;
        st_next = dir_reg ? board_ctl_pkg::ST_PTAR : board_ctl_pkg::ST_RDAT;
      end
      board_ctl_pkg::ST_RDAT: begin
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg[0]) begin
          cnt_next = 2'h0;
          st_next  = board_ctl_pkg::ST_PTAR;
        end
      end
      board_ctl_pkg::ST_PTAR: begin
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg[0]) st_next = board_ctl_pkg::ST_IDLE;
      end
      default: st_next = board_ctl_pkg::ST_IDLE;
    endcase
    if (!lframe_n && st_reg != board_ctl_pkg::ST_IDLE && st_reg != board_ctl_pkg::ST_CYC)
      st_next = (lad_i == board_ctl_pkg::LAD_START) ? board_ctl_pkg::ST_CYC
                                                    : board_ctl_pkg::ST_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg   <= board_ctl_pkg::ST_IDLE;
      cnt_reg  <= 2'h0;
      addr_reg <= 16'h0000;
      dir_reg  <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      addr_reg <= addr_next;
      dir_reg  <= dir_next;
      data_reg <= data_next;
    end
  end

  always_comb begin
    lad_oe = 1'b0;
    lad_o  = board_ctl_pkg::LAD_IDLE;
    case (st_reg)
      board_ctl_pkg::ST_SYNC: begin
        lad_oe = 1'b1;
        lad_o  = board_ctl_pkg::LAD_SYNC;
      end
      board_ctl_pkg::ST_RDAT: begin
        lad_oe = 1'b1;
        lad_o  = cnt_reg[0] ? data_reg[7:4] : data_reg[3:0];
      end
      board_ctl_pkg::ST_PTAR: lad_oe = !cnt_reg[0];
      default: lad_oe = 1'b0;
    endcase
  end

  // Register storage
  logic [7:0] regs_reg  [0:N-1];
  logic [7:0] regs_next [0:N-1];
  logic [7:0] set_v     [0:N-1];
  logic [7:0] stat_v    [0:N-1];

  always_comb begin
    for (int i = 0; i < N; i++) begin
      set_v[i]  = 8'h00;
      stat_v[i] = 8'h00;
    end
    set_v[board_ctl_pkg::OFF_TSTA]  = {5'h00, evt_rise[2:0]};
    set_v[board_ctl_pkg::OFF_SPIB]  = {6'h00, evt_rise[3], 1'b0};
    set_v[board_ctl_pkg::OFF_WDOG]  = {7'h00, evt_rise[4]};
    set_v[board_ctl_pkg::OFF_SEST]  = {4'h0, evt_rise[8:5]};
    set_v[board_ctl_pkg::OFF_GSTA]  = (gpio_s ^ regs_reg['h22]) & ~(gpio_d ^ regs_reg['h22]);
    stat_v[board_ctl_pkg::OFF_PROD]  = {1'b0, board_ctl_pkg::PROD_CODE};
    stat_v[board_ctl_pkg::OFF_PSTAT] = s2_reg[9:2];
    stat_v[board_ctl_pkg::OFF_JMP]  = {s2_reg[12], 3'h0, s2_reg[11], 1'b0, s2_reg[10], 1'b0};
    stat_v[board_ctl_pkg::OFF_TSTA] = {2'h0, s2_reg[14:13], 4'h0};
    stat_v[board_ctl_pkg::OFF_SPIB] = {7'h00, s2_reg[15]};
    stat_v[board_ctl_pkg::OFF_GIN]  = gpio_s;
    stat_v[board_ctl_pkg::OFF_SEST] = {s2_reg[16], 7'h00};
  end

  // Unused offsets hold no storage and read zero
  assign rd_val = (off < N[5:0]) ? (regs_reg[off] | stat_v[off]) : 8'h00;

  generate
    for (genvar i = 0; i < N; i++) begin : g_reg
      localparam logic [7:0] WM = board_ctl_pkg::wr_mask(i);
      localparam logic [7:0] CM = board_ctl_pkg::w1c_mask(i);
      localparam logic [7:0] RM = board_ctl_pkg::rdclr_mask(i);
      localparam board_ctl_pkg::rst_class_e CL = board_ctl_pkg::reg_class(i);
      logic hit;
      logic clr_plat;
      assign hit = (off == 6'(i));
      always_comb begin
        regs_next[i] = regs_reg[i];
        if (wr_stb && hit) begin
          regs_next[i] = (regs_reg[i] & ~WM) | (data_reg & WM);
          regs_next[i] = regs_next[i] & ~(data_reg & CM);
        end
        if (rd_stb && hit) regs_next[i] = regs_next[i] & ~RM;
        regs_next[i] = (regs_next[i] | (set_v[i] & (CM | RM))) & (WM | CM | RM);
        clr_plat = plat_s && (CL == board_ctl_pkg::CL_PLAT ||
                              (CL == board_ctl_pkg::CL_SEL && !psen_s));
        if (clr_plat) regs_next[i] = board_ctl_pkg::RST_VAL;
      end
      always_ff @(posedge mclk) begin
        if (rst) regs_reg[i] <= board_ctl_pkg::RST_VAL;
        else regs_reg[i] <= regs_next[i];
      end
      assign cfg_o[i] = regs_reg[i];
    end
  endgenerate

  assign gpio_o                 = regs_reg[board_ctl_pkg::OFF_GOUT];
  assign gpio_oe                = regs_reg[board_ctl_pkg::OFF_GDIR];
  assign programmable_indicator = regs_reg[board_ctl_pkg::OFF_PROD][7];

  // Interrupt slot levels
  logic [3:0] pend;
  logic [7:0] ctl_sel [0:3];
  assign ctl_sel[0] = regs_reg[board_ctl_pkg::OFF_TCTL];
  assign ctl_sel[1] = regs_reg[board_ctl_pkg::OFF_AUXI];
  assign ctl_sel[2] = regs_reg[board_ctl_pkg::OFF_WDOG];
  assign ctl_sel[3] = regs_reg[board_ctl_pkg::OFF_SECT];
  assign pend[0] = |(regs_reg[board_ctl_pkg::OFF_TSTA][2:0] & ctl_sel[0][2:0]);
  assign pend[1] = |(regs_reg[board_ctl_pkg::OFF_GSTA] & regs_reg[board_ctl_pkg::OFF_GMSK]);
  assign pend[2] = regs_reg[board_ctl_pkg::OFF_WDOG][0];
  assign pend[3] = |(regs_reg[board_ctl_pkg::OFF_SEST][3:0] & ctl_sel[3][3:0]);

  always_comb begin
    slot_en  = 8'h00;
    slot_lvl = 8'h00;
    for (int k = 0; k < 4; k++) begin
      if (ctl_sel[k][7]) begin
        slot_en[ctl_sel[k][6:4]]  = 1'b1;
        slot_lvl[ctl_sel[k][6:4]] = slot_lvl[ctl_sel[k][6:4]] | pend[k];
      end
    end
  end

  por_keep_a: assert property (@(posedge mclk) disable iff (rst)
    plat_s && !wr_stb |=> regs_reg['h10] == $past(regs_reg['h10]))
    else $error("power-on class register changed at platform reset");
  plat_clear_a: assert property (@(posedge mclk) disable iff (rst)
    plat_s |=> regs_reg['h03] == 8'h00 && regs_reg['h26] == 8'h00)
    else $error("platform class register not cleared");
  sel_plat_a: assert property (@(posedge mclk) disable iff (rst)
    plat_s && !psen_s |=> regs_reg['h21] == 8'h00)
    else $error("selectable register kept with power select clear");
  sel_por_a: assert property (@(posedge mclk) disable iff (rst)
    plat_s && psen_s && !wr_stb |=> regs_reg['h21] == $past(regs_reg['h21]))
    else $error("selectable register cleared with power select set");
  resv_zero_a: assert property (@(posedge mclk) disable iff (rst)
    rd_stb && (off == 6'h06 || off > 6'h32) |=> data_reg == 8'h00)
    else $error("unused offset read nonzero");
  roc_clear_a: assert property (@(posedge mclk) disable iff (rst)
    rd_stb && off == 6'h09 && !evt_rise[3] |=> !regs_reg['h09][1])
    else $error("read-to-clear bit not cleared");
  w1c_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !(wr_stb && off == 6'h26) && !plat_s
      |=> (regs_reg['h26] & $past(regs_reg['h26])) == $past(regs_reg['h26]))
    else $error("sticky status bit lost");
  slot_level_a: assert property (@(posedge mclk) disable iff (rst)
    ctl_sel[2][7] && pend[2] |-> slot_en[ctl_sel[2][6:4]] && slot_lvl[ctl_sel[2][6:4]])
    else $error("pending slot not driven high");
  write_seq_a: assert property (@(posedge mclk) disable iff (rst)
    (st_reg == board_ctl_pkg::ST_WDAT && cnt_reg == 2'h0 && lframe_n) ##1 lframe_n [*3]
      |-> st_reg == board_ctl_pkg::ST_HTAR ##1 st_reg == board_ctl_pkg::ST_SYNC)
    else $error("write cycle sequence broken");
endmodule : board_control_register_bank

// ===== testbench/lpc_host_model.sv
// LPC host model issuing byte-wide I/O cycles
module lpc_host_model (
  input  wire logic       mclk,
  input  wire logic [3:0] lad_bus,
  output logic            lframe_n,
  output logic [3:0]      lad_drv,
  output logic            lad_drv_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    lframe_n   = 1'b1;
    lad_drv    = 4'hF;
    lad_drv_oe = 1'b0;
  end

  // One byte per cycle; a wide value is sent as separate cycles
  task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] wdat,
                          output logic [7:0] rdat, output logic ok);
    rdat = 8'hXX;
    ok   = 1'b0;
    @(negedge mclk);
    lframe_n   = 1'b0;
    lad_drv    = 4'h0;
    lad_drv_oe = 1'b1;
    @(negedge mclk);
    lframe_n = 1'b1;
    lad_drv  = {2'b00, wr, 1'b0};
    for (int i = 3; i >= 0; i--) begin
      @(negedge mclk);
      lad_drv = addr[4*i +: 4];
    end
    if (wr) begin
      @(negedge mclk);
      lad_drv = wdat[3:0];
      @(negedge mclk);
      lad_drv = wdat[7:4];
    end
    @(negedge mclk);
    lad_drv = 4'hF;
    @(negedge mclk);
    lad_drv_oe = 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge mclk);
      ok = (lad_bus === 4'h0);
    end
    if (ok && !wr) begin
      @(negedge mclk);
      rdat[3:0] = lad_bus;
      @(negedge mclk);
      rdat[7:4] = lad_bus;
    end
    @(negedge mclk);
    @(negedge mclk);
  endtask : io_cycle
endmodule : lpc_host_model

// ===== testbench/tb_top.sv
// Self-checking bench for the board control register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                mclk, rst, plat_rst, psel, spi_busy, battlow, spi_evt;
  logic [7:0]                          prod_status, gpio_in, gpio_o, gpio_oe, slot_en, slot_lvl;
  logic [7:0]                          rd;
  logic [3:0]                          sys_evt, lad_o, lad_drv, lad_bus;
  logic                                lad_oe, lad_drv_oe, lframe_n, pind, ok;
  logic [board_ctl_pkg::NREG-1:0][7:0] cfg_o;
  int                                  failures = 0;
  int                                  num_checks = 0;

  assign lad_bus = lad_oe ? lad_o : (lad_drv_oe ? lad_drv : 4'hF);
  always #50 mclk = ~mclk;

  board_control_register_bank DUT (
    .mclk(mclk), .rst(rst), .lframe_n(lframe_n), .lad_i(lad_bus), .lad_o(lad_o),
    .lad_oe(lad_oe), .plat_rst(plat_rst), .power_select_control_bit(psel),
    .prod_status(prod_status), .jumper_in(3'h0), .tmr_in(2'h0), .spi_busy(spi_busy),
    .battlow(battlow), .gpio_in(gpio_in), .timer_evt(3'h0), .spi_evt(spi_evt),
    .wdt_evt(1'b0), .sys_evt(sys_evt), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .programmable_indicator(pind), .cfg_o(cfg_o), .slot_en(slot_en), .slot_lvl(slot_lvl)
  );
  lpc_host_model host (.mclk(mclk), .lad_bus(lad_bus), .lframe_n(lframe_n),
                       .lad_drv(lad_drv), .lad_drv_oe(lad_drv_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask : ticks

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    host.io_cycle(1'b1, board_ctl_pkg::WIN_BASE + {8'h00, off}, d, rd, ok);
    chk({7'h00, ok}, 8'h01, $sformatf("write sync %h", off));
  endtask : wr

  task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
    host.io_cycle(1'b0, board_ctl_pkg::WIN_BASE + {8'h00, off}, 8'h00, rd, ok);
    chk(rd, exp, $sformatf("read %h", off));
  endtask : rdc

  task automatic pulse_plat;
    plat_rst = 1'b1;
    ticks(6);
    plat_rst = 1'b0;
    ticks(4);
  endtask : pulse_plat

  task automatic t_reset_state;
    rdc(8'h00, {1'b0, board_ctl_pkg::PROD_CODE});
    rdc(8'h01, 8'hC5);
    rdc(8'h03, 8'h00);
  endtask : t_reset_state

  task automatic t_masks;
    logic [7:0] off [7] = '{8'h05, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h2A, 8'h2C};
    logic [7:0] msk [7] = '{8'hFF, 8'h76, 8'h03, 8'h70, 8'h04, 8'h03, 8'h01};
    for (int i = 0; i < 7; i++) begin
      wr(off[i], msk[i]);
      rdc(off[i], msk[i]);
      chk(cfg_o[off[i]], msk[i], "stored value");
      wr(off[i], 8'h00);
      rdc(off[i], 8'h00);
    end
    wr(8'h00, 8'h80);
    chk({7'h00, pind}, 8'h01, "indicator on");
    wr(8'h00, 8'h00);
  endtask : t_masks

  task automatic t_unused;
    logic [7:0] off [4] = '{8'h06, 8'h13, 8'h2D, 8'h3F};
    foreach (off[i]) begin
      wr(off[i], 8'hFF);
      rdc(off[i], 8'h00);
    end
  endtask : t_unused

  task automatic t_reset_classes;
    wr(8'h10, 8'h03);
    wr(8'h03, 8'hF7);
    wr(8'h21, 8'hAA);
    pulse_plat();
    rdc(8'h10, 8'h03);
    rdc(8'h03, 8'h00);
    rdc(8'h21, 8'h00);
    chk(gpio_oe, 8'h00, "dir after platform reset");
    psel = 1'b1;
    ticks(4);
    wr(8'h21, 8'h55);
    wr(8'h23, 8'h0F);
    pulse_plat();
    rdc(8'h21, 8'h55);
    chk(gpio_o, 8'h0F, "out kept");
    rst = 1'b1;
    ticks(2);
    rst = 1'b0;
    ticks(1);
    rdc(8'h10, 8'h00);
    rdc(8'h21, 8'h00);
    psel = 1'b0;
  endtask : t_reset_classes

  task automatic t_sticky;
    gpio_in = 8'h01;
    ticks(4);
    rdc(8'h26, 8'h01);
    wr(8'h26, 8'h00);
    rdc(8'h26, 8'h01);
    wr(8'h26, 8'h01);
    rdc(8'h26, 8'h00);
    sys_evt = 4'h4;
    battlow = 1'b1;
    ticks(4);
    rdc(8'h31, 8'h84);
    wr(8'h31, 8'h08);
    rdc(8'h31, 8'h84);
    wr(8'h31, 8'h04);
    rdc(8'h31, 8'h80);
    battlow = 1'b0;
    sys_evt = 4'h0;
    spi_busy = 1'b1;
    spi_evt = 1'b1;
    ticks(4);
    rdc(8'h09, 8'h03);
    rdc(8'h09, 8'h01);
    spi_busy = 1'b0;
  endtask : t_sticky

  task automatic t_slot;
    wr(8'h25, 8'h01);
    for (int s = 0; s < 8; s++) begin
      wr(8'h2B, {1'b1, 3'(s), 4'h0});
      chk(slot_en, 8'h01 << s, "slot enable");
      chk(slot_lvl, 8'h00, "slot idle low");
    end
    gpio_in = 8'h00;
    ticks(4);
    gpio_in = 8'h01;
    ticks(4);
    chk(slot_lvl, 8'h80, "slot pending high");
    wr(8'h26, 8'h01);
    chk(slot_lvl, 8'h00, "slot cleared");
  endtask : t_slot

  task automatic t_wide;
    wr(8'h2E, 8'h34);
    wr(8'h2F, 8'h12);
    rdc(8'h2E, 8'h34);
    rdc(8'h2F, 8'h12);
    host.io_cycle(1'b1, 16'h0D2E, 8'hFF, rd, ok);
    chk({7'h00, ok}, 8'h00, "outside window answered");
    rdc(8'h2E, 8'h34);
  endtask : t_wide

  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'b0;
    {rst, plat_rst, psel, spi_busy, battlow, spi_evt} = 6'h20;
    prod_status = 8'hC5;
    gpio_in = 8'h00;
    sys_evt = 4'h0;
    ticks(5);
    rst = 1'b0;
    ticks(1);
    t_reset_state();
    t_masks();
    t_unused();
    t_reset_classes();
    t_sticky();
    t_slot();
    t_wide();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    $display("MISMATCH %0t watchdog expired", $time);
    failures++;
    wrap_up();
  end
endmodule : tb_top
